// ---- rtl/sra_readout.sv ----
// conversion control and serial readout of the converter, core and link domains
`timescale 1ns/1ps
module sra_readout
    import sra_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC
) (
    // core clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // pins from the host
    input wire logic convert_start_i,
    input wire logic sdi_i,
    input wire logic sck_i,
    // converter core result, taken on the start rise before the core is powered
    input wire logic [RES_BITS-1:0] result_i,
    // serial output pin, enable low while driven
    output logic sdo_o,
    output logic sdo_oe_n_o,
    // core status
    output logic core_pwr_o,
    output logic conv_done_o
);

    // ---------------------------------------------------------------
    // core clock domain
    // ---------------------------------------------------------------

    sra_pins_t raw;
    sra_pins_t syn;
    sra_state_t state;
    sra_frame_t frame;
    logic cnv_d;
    logic cnv_rise;
    logic cs_act;
    logic [CONV_CNT_W-1:0] conv_cnt;
    logic conv_end;
    logic chain_busy;
    logic [RES_BITS-1:0] sample;
    logic load_tgl;
    logic frame_live;
    logic armed;
    logic drv;
    logic next_drv;
    logic head_bit;

    // link-domain state read back by the output stage
    logic seen_tgl;
    logic link_bit;
    logic spent;
    logic started;

    assign raw.convert_start = convert_start_i;
    assign raw.sdi = sdi_i;
    assign raw.sck = sck_i;

    // every pin level passes two flops before the core logic sees it
    sra_sync #(
        .W($bits(sra_pins_t))
    ) u_sync (
        .clk_i(mclk_i),
        .d_i(raw),
        .q_o(syn)
    );

    // edge history of the start pin
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cnv_d <= 1'b0;
        end else begin
            cnv_d <= syn.convert_start;
        end
    end

    assign cnv_rise = syn.convert_start & ~cnv_d;
    // select line: low start or low serial input addresses the part
    assign cs_act = ~(syn.convert_start & syn.sdi);
    assign conv_end = (state == ST_CONV) &&
        (conv_cnt == CONV_CNT_W'(CONV_CYCLES - 1));

    // sequencing: pins are ignored while converting
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cnv_rise) begin
                        state <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_end) begin
                        state <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (cnv_rise) begin
                        state <= ST_CONV;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // conversion timer on the internal clock
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            conv_cnt <= CONV_CNT_RST;
        end else if (state == ST_CONV) begin
            conv_cnt <= conv_cnt + 1'b1;
        end else begin
            conv_cnt <= CONV_CNT_RST;
        end
    end

    // straps are taken on the start rise and the frame is built once per
    // conversion, then left alone, so the link side can read it without a
    // word crossing of its own; one process since both write the frame
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            frame.chain <= 1'b0;
            chain_busy <= 1'b0;
            sample <= '0;
            frame.word <= '0;
            frame.len <= LEN_PLAIN;
            load_tgl <= 1'b0;
        end else if (cnv_rise && state != ST_CONV) begin
            frame.chain <= ~syn.sdi;
            chain_busy <= syn.sck;
            sample <= result_i;
        end else if (conv_end) begin
            // busy in select mode: an addressing low at conversion end
            if (frame.chain ? chain_busy : cs_act) begin
                frame.word <= {frame.chain, sample};
                frame.len <= LEN_BUSY;
            end else begin
                frame.word <= {sample, 1'b0};
                frame.len <= LEN_PLAIN;
            end
            load_tgl <= ~load_tgl;
        end
    end

    // frame lifetime: opens at conversion end, closes on deselect or new start
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            frame_live <= 1'b0;
            armed <= 1'b0;
        end else if (conv_end) begin
            frame_live <= 1'b1;
            armed <= 1'b0;
        end else if (state != ST_READ || cnv_rise) begin
            frame_live <= 1'b0;
            armed <= 1'b0;
        end else if (!syn.convert_start && !syn.sdi) begin
            // both pins low can only mean the readback is over
            frame_live <= 1'b0;
            armed <= 1'b0;
        end else if (!frame.chain) begin
            if (cs_act) begin
                armed <= 1'b1;
            end else if (armed) begin
                frame_live <= 1'b0;
            end
        end
    end

    // pin drive decision, one flop behind the synchronised levels
    always_comb begin
        next_drv = 1'b0;
        if (state == ST_CONV || (state != ST_READ && cnv_rise)) begin
            next_drv = 1'b0;
        end else if (frame_live && !(state == ST_READ && cnv_rise)) begin
            // chain keeps driving for the whole readback
            next_drv = frame.chain | cs_act;
        end else if (!syn.convert_start && !syn.sdi) begin
            next_drv = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            drv <= 1'b0;
        end else begin
            drv <= next_drv;
        end
    end

    // level shown before the first falling clock: start bit or MSB
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            head_bit <= 1'b0;
        end else if (conv_end) begin
            head_bit <= (frame.chain ? chain_busy : cs_act) ?
                frame.chain : sample[RES_BITS-1];
        end else if (!frame_live || (!syn.convert_start && !syn.sdi)) begin
            // cleared with the frame close so no stale bit is driven
            head_bit <= 1'b0;
        end
    end

    // core power and completion report
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            core_pwr_o <= 1'b0;
            conv_done_o <= 1'b0;
        end else begin
            core_pwr_o <= (state == ST_CONV) && !conv_end;
            conv_done_o <= conv_end;
        end
    end

    // output stage: a combinational pick between two flops is the price of
    // a link clock that is faster than the core clock and stops between frames
    assign started = (seen_tgl == load_tgl);
    assign sdo_o = (frame_live && started) ? link_bit : head_bit;
    assign sdo_oe_n_o = ~(drv & ~(started & spent & ~frame.chain & frame_live));

    // ---------------------------------------------------------------
    // link clock domain, falling edges of the serial clock
    // ---------------------------------------------------------------

    logic lrst_meta;
    logic lrst;
    logic [FALL_CNT_W-1:0] fall_cnt;
    logic [FALL_CNT_W-1:0] next_cnt;
    logic [FRAME_BITS-1:0] dly;
    logic [FRAME_BITS-1:0] next_dly;
    logic next_bit;
    logic fresh;

    // reset reaches the link side only while the serial clock runs
    always_ff @(negedge sck_i) begin
        lrst_meta <= srst_i;
        lrst <= lrst_meta;
    end

    // edge count and shifted bit for this falling edge
    always_comb begin
        fresh = (seen_tgl != load_tgl);
        next_dly = {dly[FRAME_BITS-2:0], sdi_i};
        if (fresh) begin
            next_cnt = 5'h01;
        end else if (fall_cnt == FALL_CNT_MAX) begin
            next_cnt = fall_cnt;
        end else begin
            next_cnt = fall_cnt + 1'b1;
        end
        if (next_cnt < frame.len) begin
            next_bit = frame.word[FRAME_BITS - 1 - 32'(next_cnt)];
        end else begin
            // upstream data follows our own bits after one frame length
            next_bit = next_dly[frame.len - 1'b1];
        end
    end

    // the frame word is held steady by the core from conversion end on,
    // long before the host may clock, so it is read here directly
    always_ff @(negedge sck_i) begin
        if (lrst) begin
            seen_tgl <= 1'b0;
            fall_cnt <= FALL_CNT_RST;
            dly <= '0;
            link_bit <= 1'b0;
            spent <= 1'b0;
        end else begin
            seen_tgl <= load_tgl;
            fall_cnt <= next_cnt;
            dly <= next_dly;
            link_bit <= next_bit;
            spent <= (next_cnt >= frame.len);
        end
    end

endmodule

// ---- rtl/sra_pkg.sv ----
// constants, types and shared values of the serial readout block
package sra_pkg;

    // result and frame geometry
    localparam int RES_BITS = 18;
    localparam int FRAME_BITS = RES_BITS + 1;
    localparam logic [4:0] LEN_PLAIN = 5'h12;
    localparam logic [4:0] LEN_BUSY = 5'h13;
    localparam int FALL_CNT_W = 5;
    localparam logic [FALL_CNT_W-1:0] FALL_CNT_MAX = 5'h1f;

    // conversion timing on the core clock
    localparam int MCLK_MHZ = 50;
    localparam int T_CONV_NS = 2200;
    localparam int CONV_CYC = (T_CONV_NS * MCLK_MHZ + 999) / 1000;
    localparam int CONV_CNT_W = 12;

    // values after reset
    localparam logic [CONV_CNT_W-1:0] CONV_CNT_RST = 12'h000;
    localparam logic [FALL_CNT_W-1:0] FALL_CNT_RST = 5'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_READ = 2'b10
    } sra_state_t;

    // pin levels that travel together through the synchroniser
    typedef struct packed {
        logic convert_start;
        logic sdi;
        logic sck;
    } sra_pins_t;

    // frame handed to the link side at conversion end
    typedef struct packed {
        logic [FRAME_BITS-1:0] word;
        logic [4:0] len;
        logic chain;
    } sra_frame_t;

endpackage

// ---- rtl/sra_sync.sv ----
// two-stage level synchroniser, one chain per bit
`timescale 1ns/1ps
module sra_sync #(
    parameter int W = 3
) (
    // clock
    input wire logic clk_i,
    // asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            always_ff @(posedge clk_i) begin
                meta[gi] <= d_i[gi];
                q_o[gi] <= meta[gi];
            end
        end
    endgenerate
endmodule

// ---- tb/sra_readout_chk.sv ----
// port-level assertions for the serial readout block
`timescale 1ns/1ps
module sra_readout_chk
    import sra_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC
) (
    // core clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // pins and core signals
    input wire logic convert_start_i,
    input wire logic sdi_i,
    input wire logic sck_i,
    input wire logic [RES_BITS-1:0] result_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_n_o,
    input wire logic core_pwr_o,
    input wire logic conv_done_o
);
    localparam int LO = CONV_CYCLES - 2;
    localparam int HI = CONV_CYCLES + 2;
    logic sel_q;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // mode strap as seen behind the synchroniser delay
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sel_q <= 1'b0;
        end else if ($rose(core_pwr_o)) begin
            sel_q <= $past(sdi_i, 3);
        end
    end
    AST_DONE_PULSE: assert property (conv_done_o |=> !conv_done_o)
        else $error("conversion end pulse too long");
    AST_PWR_OFF: assert property (conv_done_o |=> !core_pwr_o [*2])
        else $error("core still powered after conversion end");
    AST_START: assert property ($rose(convert_start_i) && !core_pwr_o |-> ##[2:5] core_pwr_o)
        else $error("start rise did not begin a conversion");
    AST_CONV_LEN: assert property ($rose(core_pwr_o) |-> ##[LO:HI] conv_done_o)
        else $error("conversion length wrong");
    AST_FLOAT_CONV: assert property (core_pwr_o && $past(core_pwr_o) && sel_q |-> sdo_oe_n_o)
        else $error("output driven during select conversion");
    // pins as the core saw them at conversion end, three samples back
    AST_BUSY_DRIVE: assert property (conv_done_o
        && !(sel_q && $past(convert_start_i, 3) && $past(sdi_i, 3)) |-> ##[0:2] !sdo_oe_n_o)
        else $error("output not driven at conversion end");
    AST_NOBUSY_Z: assert property (conv_done_o && sel_q
        && $past(convert_start_i, 3) && $past(sdi_i, 3) |=> sdo_oe_n_o [*3])
        else $error("output driven without selection");
    AST_DESELECT: assert property (sel_q && !core_pwr_o && $rose(sdi_i) |-> ##[1:6] sdo_oe_n_o)
        else $error("output not floated on deselect");
    AST_LOW_IDLE: assert property ((!convert_start_i && !sdi_i && !core_pwr_o) [*5] |-> !sdo_oe_n_o && !sdo_o)
        else $error("output not driven low with both pins low");
endmodule

bind sra_readout sra_readout_chk #(.CONV_CYCLES(CONV_CYCLES)) sra_readout_chk_inst (
    .mclk_i(mclk_i), .srst_i(srst_i), .convert_start_i(convert_start_i),
    .sdi_i(sdi_i), .sck_i(sck_i), .result_i(result_i), .sdo_o(sdo_o),
    .sdo_oe_n_o(sdo_oe_n_o), .core_pwr_o(core_pwr_o), .conv_done_o(conv_done_o)
);

// ---- tb/sra_host_model.sv ----
// host side: serial clock, pull-up on the output line, bit sampling
`timescale 1ns/1ps
module sra_host_model (
    // device output pin
    input wire logic sdo_i,
    input wire logic sdo_oe_n_i,
    // host clock and resolved line
    output logic sck_o,
    output logic line_o
);
    event got;
    initial sck_o = 1'b0;
    // pull-up, single device so no contention on the line
    assign line_o = sdo_oe_n_i ? 1'b1 : sdo_i;
    // clock level outside frames, used as the chain busy strap
    task automatic level(input logic b);
        sck_o = b;
    endtask
    // 12 ns clock in bursts of n periods, sampling on the rising edge
    task automatic clk(input int n, input bit smp);
        #3;
        repeat (n) begin
            #6 sck_o = 1'b1;
            if (smp) ->got;
            #6 sck_o = 1'b0;
        end
    endtask
endmodule

// ---- tb/sra_readout_bench.sv ----
// self-checking bench for the serial readout block
`timescale 1ns/1ps
module sra_readout_bench
    import sra_pkg::*;
;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic convert_start_i = 1'b0;
    logic sdi_i = 1'b0;
    logic [RES_BITS-1:0] result_i = '0;
    logic sck, sdo, sdo_oe_n, core_pwr, conv_done, line, e;
    logic exp_q[$];
    int miscompares = 0;
    int n_tests = 0;
    int m;
    // 50 MHz core clock
    always #10 mclk_i = ~mclk_i;
    sra_readout #(.CONV_CYCLES(20)) sra_readout_inst (
        .mclk_i(mclk_i), .srst_i(srst_i), .convert_start_i(convert_start_i),
        .sdi_i(sdi_i), .sck_i(sck), .result_i(result_i), .sdo_o(sdo),
        .sdo_oe_n_o(sdo_oe_n), .core_pwr_o(core_pwr), .conv_done_o(conv_done)
    );
    sra_host_model sra_host_model_inst (
        .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n), .sck_o(sck), .line_o(line)
    );
    // each sampled bit takes the oldest expectation
    always @(sra_host_model_inst.got) begin
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 1'bx;
        n_tests++;
        if (line !== e) begin
            miscompares++;
            $display("[FAIL] sdo line: expected %b, seen %b", e, line);
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // modes: 0 4-wire plain, 1 3-wire busy, 2 4-wire busy, 3 chain, 4 chain busy
    task automatic run(input int md);
        logic [RES_BITS-1:0] r;
        int k;
        r = RES_BITS'($urandom);
        result_i = r;
        sdi_i = (md < 3);
        sra_host_model_inst.level(md == 4);
        @(negedge mclk_i);
        convert_start_i = 1'b1;
        repeat (6) @(negedge mclk_i);
        result_i = ~r;
        sra_host_model_inst.level(1'b0);
        if (md == 1) convert_start_i = 1'b0;
        if (md == 2) sdi_i = 1'b0;
        for (k = 0; k < 100 && conv_done !== 1'b1; k++) @(negedge mclk_i);
        n_tests++;
        if (conv_done !== 1'b1) begin
            miscompares++;
            $display("[FAIL] conv_done: expected 1, seen %b", conv_done);
        end
        if (md == 3) sdi_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        if (md == 0) sdi_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        if (md == 1 || md == 2 || md == 4) exp_q.push_back(md == 4);
        for (k = RES_BITS - 1; k >= 0; k--) exp_q.push_back(r[k]);
        exp_q.push_back(md != 4);
        if (md == 3) exp_q.push_back(1'b1);
        sra_host_model_inst.clk((md == 0) ? 19 : (md == 2) ? 7 : 20, 1'b1);
        @(negedge mclk_i);
        if (md == 2) begin
            exp_q.delete();
            sdi_i = 1'b1;
            repeat (6) @(negedge mclk_i);
            exp_q.push_back(1'b1);
            sra_host_model_inst.clk(1, 1'b1);
            @(negedge mclk_i);
        end
        sdi_i = 1'b0;
        // flush upstream ones so the idle line is not stale chain data
        if (md == 3) sra_host_model_inst.clk(18, 1'b0);
        @(negedge mclk_i);
        convert_start_i = 1'b0;
        repeat (8) @(negedge mclk_i);
        $display("mode %0d finished", md);
    endtask
    // main sequence
    initial begin
        void'($urandom(32'h128c0dfd));
        repeat (2) @(posedge mclk_i);
        sra_host_model_inst.clk(3, 1'b0);
        @(negedge mclk_i);
        srst_i = 1'b0;
        // link reset trails the release by two serial falls
        sra_host_model_inst.clk(2, 1'b0);
        repeat (4) @(negedge mclk_i);
        for (m = 0; m < 5; m++) run(m);
        exp_q.push_back(1'b0);
        sra_host_model_inst.clk(1, 1'b1);
        repeat (2) @(negedge mclk_i);
        give_verdict();
    end
    // watchdog, far beyond the few microseconds the tests need
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end
endmodule
